// file: inc/bidir_queue_params.svh
// Constants for the two-way queue port block
//
// Behaviour
// - Port A write stores queue or mailbox word
// - Port B read gives queue word or mailbox
// - Selects start a transfer only when transfer enable high
// - Flags pass two stages into port clock
// - Each port's flags run on its clock
// - Queue read only while not-empty flag high
// - Read pointer advances per output-register load
// - Not-empty rises on second reading edge
// - First sync edge must follow write by skew
// - Queue write only while not-full flag high
// - Write pointer advances per stored word
// - Not-full rises on second writing edge
// - First sync edge must follow read by skew
// - Almost-empty low at X or fewer words
// - Almost-empty rises on second reading edge
// - Almost-full low at 64 minus X words
// - Flags follow the fill-level table
// - One preset offset shared by both queues
// - Offset select pins sampled at reset release
// - Reset clears pointers, sets flag reset levels
// - Mailbox write lowers flag, blocks further writes
// - Drive data bus only when selected reading
`ifndef BIDIR_QUEUE_PARAMS_SVH
`define BIDIR_QUEUE_PARAMS_SVH

`define WORD_W          36
`define QUEUE_DEPTH     64
`define PTR_W           6
`define OFFSET_W        5
`define BUF_ENTRIES     2
`define OFFSET_SEL_HH   2'b11
`define OFFSET_SEL_HL   2'b10
`define OFFSET_SEL_LH   2'b01
`define OFFSET_VAL_HH   5'h10
`define OFFSET_VAL_HL   5'h0c
`define OFFSET_VAL_LH   5'h08
`define OFFSET_VAL_LL   5'h04
`define SYNC_CLEAR      2'b00
`define SYNC_SET        2'b11
`define MAIL_FLAG_RST   1'b1

`endif

// file: inc/bidir_queue_pkg.sv
// Types shared by the two-way queue port block
`include "bidir_queue_params.svh"

package bidir_queue_pkg;

  // Pins of one port as sampled by mclk
  typedef struct packed {
    logic                clock;
    logic                selectN;
    logic                writeNotRead;
    logic                transferEnable;
    logic                mailboxSelect;
    logic [`WORD_W-1:0]  data;
  } portPins_t;

  // Per-port state: two sampling stages, edge history, bus output
  typedef struct packed {
    portPins_t           meta;
    portPins_t           stable;
    logic                clkPrev;
    logic [`WORD_W-1:0]  dataOut;
  } portState_t;

  // Per-direction state: pointers, buffer, mailbox, flag pipelines
  typedef struct packed {
    logic [`PTR_W:0]                       wrPtrGray;
    logic [`PTR_W:0]                       rdPtrGray;
    logic [`BUF_ENTRIES-1:0][`WORD_W-1:0]  bufWords;
    logic [1:0]                            bufCount;
    logic [`WORD_W-1:0]                    mail;
    logic                                  mailFlagN;
    logic [`WORD_W-1:0]                    outWord;
    logic [1:0]                            emptySync;
    logic [1:0]                            aeSync;
    logic [1:0]                            fullSync;
    logic [1:0]                            afSync;
  } dirState_t;

  // Whole block state
  typedef struct packed {
    dirState_t  [1:0]       dir;
    portState_t [1:0]       port;
    logic [1:0]             selMeta;
    logic [1:0]             selStable;
    logic [`OFFSET_W-1:0]   offset;
  } coreState_t;

endpackage

// file: core/queue_word_mem.sv
// Word store of one queue, registered read data
module queue_word_mem #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             mclk,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  // Storage plus read register
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [WIDTH-1:0]            rdData;
  } memState_t;

  memState_t memReg;   // Current contents
  memState_t memNext;  // Next contents

  ////////////////////////////////////////////////////////////////////////////
  // Write and read; a same-cycle hit on one address returns the old word
  always_comb begin
    memNext = memReg;
    if (wrEn) begin
      memNext.words[wrAddr] = wrData;
    end
    memNext.rdData = memReg.words[rdAddr];
  end

  // No reset: contents are don't-care until written
  always_ff @(posedge mclk) begin
    memReg <= memNext;
  end

  assign rdData = memReg.rdData;

endmodule

// file: core/bidir_queue_port.sv
// Two-way queue pair with mailboxes and synchronised fill flags
`include "bidir_queue_params.svh"

module bidir_queue_port
  import bidir_queue_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                portAClock,
  input  wire logic                portASelectN,
  input  wire logic                portAWriteNotRead,
  input  wire logic                portATransferEnable,
  input  wire logic                portAMailboxSelect,
  input  wire logic [`WORD_W-1:0]  portADataIn,
  output logic      [`WORD_W-1:0]  portADataOut,
  output logic                     portADataOe,
  output logic                     portANotEmpty,
  output logic                     portAAlmostEmptyN,
  output logic                     portANotFull,
  output logic                     portAAlmostFullN,
  input  wire logic                portBClock,
  input  wire logic                portBSelectN,
  input  wire logic                portBWriteNotRead,
  input  wire logic                portBTransferEnable,
  input  wire logic                portBMailboxSelect,
  input  wire logic [`WORD_W-1:0]  portBDataIn,
  output logic      [`WORD_W-1:0]  portBDataOut,
  output logic                     portBDataOe,
  output logic                     portBNotEmpty,
  output logic                     portBAlmostEmptyN,
  output logic                     portBNotFull,
  output logic                     portBAlmostFullN,
  output logic                     aToBMailFlagN,
  output logic                     bToAMailFlagN,
  input  wire logic                offsetSelectLo,
  input  wire logic                offsetSelectHi
);

  localparam int PW = `PTR_W;                       // Address bits
  localparam logic [PW:0] DEPTH_C = (PW+1)'(`QUEUE_DEPTH);

  coreState_t stateReg;   // All block state
  coreState_t stateNext;  // Its next value

  portPins_t  pinsIn [2];  // Raw pins, index 0 port A, 1 port B

  logic [1:0]           portEdge;   // Sampled rising edge of port clock
  logic [1:0]           wrEv;       // Qualified write request per port
  logic [1:0]           rdEv;       // Qualified read request per port
  logic [1:0][PW:0]     memCount;   // Words in store per direction
  logic [1:0][PW:0]     occ;        // Words in store plus buffer
  logic [1:0]           bufReady;   // Buffer can take a word
  logic [1:0]           qWrite;     // Accepted queue write
  logic [1:0]           mWrite;     // Accepted mailbox write
  logic [1:0]           qRead;      // Accepted queue read
  logic [1:0]           mRead;      // Mailbox read
  logic [1:0]           drain;      // Buffer head moves into store
  logic [`WORD_W-1:0]   memRdata [2];  // Store read data
  logic [1:0][PW-1:0]   wrAddr;     // Store write address per direction
  logic [1:0][PW-1:0]   rdAddr;     // Store read address per direction

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pointers carry one wrap bit above the address, so a full store and
  // an empty one differ in that bit alone; gray moves one bit per step,
  // so a pointer copy is never seen half-updated
  // Binary to gray
  function automatic logic [PW:0] toGray(input logic [PW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary
  function automatic logic [PW:0] fromGray(input logic [PW:0] g);
    logic [PW:0] b;
    b = '0;
    b[PW] = g[PW];
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Next gray pointer
  function automatic logic [PW:0] incGray(input logic [PW:0] g);
    return toGray((PW+1)'(fromGray(g) + 1'b1));
  endfunction

  // Flag pipeline: a bad level drops at once, a good one needs two edges
  function automatic logic [1:0] flagStep(input logic [1:0] st,
                                          input logic good,
                                          input logic tick);
    logic [1:0] r;
    r = st;
    if (!good) begin
      r = `SYNC_CLEAR;
    end else if (tick) begin
      r = {st[0], 1'b1};
    end
    return r;
  endfunction

  // Offset straps to threshold
  function automatic logic [`OFFSET_W-1:0] offsetOf(input logic [1:0] sel);
    logic [`OFFSET_W-1:0] v;
    case (sel)
      `OFFSET_SEL_HH: v = `OFFSET_VAL_HH;
      `OFFSET_SEL_HL: v = `OFFSET_VAL_HL;
      `OFFSET_SEL_LH: v = `OFFSET_VAL_LH;
      default:        v = `OFFSET_VAL_LL;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin gathering
  // Positional patterns follow the field order of portPins_t

  assign pinsIn[0] = '{portAClock, portASelectN, portAWriteNotRead,
                       portATransferEnable, portAMailboxSelect, portADataIn};
  assign pinsIn[1] = '{portBClock, portBSelectN, portBWriteNotRead,
                       portBTransferEnable, portBMailboxSelect, portBDataIn};

  ////////////////////////////////////////////////////////////////////////////
  // Port request decode, from the second sampling stage only

  for (genvar p = 0; p < 2; p++) begin : gPort
    // Port clock rising edge seen by mclk; skew below one mclk may slip
    // the first sync edge to the next port cycle
    assign portEdge[p] = stateReg.port[p].stable.clock & ~stateReg.port[p].clkPrev;
    // Selects are looked at only with enable high on an edge
    assign wrEv[p] = portEdge[p] & ~stateReg.port[p].stable.selectN
                     & stateReg.port[p].stable.transferEnable
                     & stateReg.port[p].stable.writeNotRead;
    assign rdEv[p] = portEdge[p] & ~stateReg.port[p].stable.selectN
                     & stateReg.port[p].stable.transferEnable
                     & ~stateReg.port[p].stable.writeNotRead;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-direction datapath: 0 writes on A, reads on B; 1 the reverse

  for (genvar d = 0; d < 2; d++) begin : gDir
    localparam int W = d;      // Writing port
    localparam int R = 1 - d;  // Reading port

    // Gray pointers are decoded before any subtraction
    assign memCount[d] = (PW+1)'(fromGray(stateReg.dir[d].wrPtrGray)
                                 - fromGray(stateReg.dir[d].rdPtrGray));
    assign occ[d] = (PW+1)'(memCount[d] + {{(PW-1){1'b0}}, stateReg.dir[d].bufCount});
    assign bufReady[d] = stateReg.dir[d].bufCount < 2'(`BUF_ENTRIES);

    // Queue write needs the not-full flag; a stalled buffer also refuses
    assign qWrite[d] = wrEv[W] & ~stateReg.port[W].stable.mailboxSelect
                       & stateReg.dir[d].fullSync[1] & bufReady[d];
    // Mailbox write ignored while its flag is low
    assign mWrite[d] = wrEv[W] & stateReg.port[W].stable.mailboxSelect
                       & stateReg.dir[d].mailFlagN;
    // Queue read needs the not-empty flag and a stored word
    assign qRead[d] = rdEv[R] & ~stateReg.port[R].stable.mailboxSelect
                      & stateReg.dir[d].emptySync[1] & (memCount[d] != '0);
    assign mRead[d] = rdEv[R] & stateReg.port[R].stable.mailboxSelect;
    // Store refuses when full, stalling the buffer
    assign drain[d] = (stateReg.dir[d].bufCount != 2'h0) & (memCount[d] < DEPTH_C);

    // Binary store addresses; the wrap bit is dropped on purpose
    assign wrAddr[d] = PW'(fromGray(stateReg.dir[d].wrPtrGray));
    assign rdAddr[d] = PW'(fromGray(stateReg.dir[d].rdPtrGray));

    // Read address tracks the read pointer, so its word waits registered
    queue_word_mem #(
      .WIDTH (`WORD_W),
      .DEPTH (`QUEUE_DEPTH),
      .AW    (PW)
    ) uMem (
      .mclk   (mclk),
      .wrEn   (drain[d]),
      .wrAddr (wrAddr[d]),
      .wrData (stateReg.dir[d].bufWords[0]),
      .rdAddr (rdAddr[d]),
      .rdData (memRdata[d])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [1:0] cnt;
    logic       idx;
    cnt = 2'h0;
    idx = 1'b0;
    stateNext = stateReg;

    // Two-flop pin sampling; only the second stage feeds logic
    for (int p = 0; p < 2; p++) begin
      stateNext.port[p].meta    = pinsIn[p];
      stateNext.port[p].stable  = stateReg.port[p].meta;
      stateNext.port[p].clkPrev = stateReg.port[p].stable.clock;
      // Bus word from mailbox or output register, chosen by mailbox select
      stateNext.port[p].dataOut = stateReg.port[p].stable.mailboxSelect
                                  ? stateReg.dir[1-p].mail
                                  : stateReg.dir[1-p].outWord;
    end
    stateNext.selMeta   = {offsetSelectHi, offsetSelectLo};
    stateNext.selStable = stateReg.selMeta;

    for (int d = 0; d < 2; d++) begin
      // Two-entry buffer between port write and store; buffered words count
      // in occupancy, so the flags never promise room the store lacks
      cnt = stateReg.dir[d].bufCount;
      idx = cnt[0] & ~drain[d];
      if (drain[d]) begin
        stateNext.dir[d].bufWords[0] = stateReg.dir[d].bufWords[1];
        stateNext.dir[d].wrPtrGray   = incGray(stateReg.dir[d].wrPtrGray);
      end
      if (qWrite[d]) begin
        stateNext.dir[d].bufWords[idx] = stateReg.port[d].stable.data;
      end
      stateNext.dir[d].bufCount = 2'(cnt + {1'b0, qWrite[d]} - {1'b0, drain[d]});

      // Output register load moves the read pointer
      if (qRead[d]) begin
        stateNext.dir[d].outWord   = memRdata[d];
        stateNext.dir[d].rdPtrGray = incGray(stateReg.dir[d].rdPtrGray);
      end

      // Mailbox: a write landing with a read leaves the flag low
      if (mRead[d]) begin
        stateNext.dir[d].mailFlagN = 1'b1;
      end
      if (mWrite[d]) begin
        stateNext.dir[d].mail      = stateReg.port[d].stable.data;
        stateNext.dir[d].mailFlagN = 1'b0;
      end

      // Empty-side flags step on the reading port's edges
      stateNext.dir[d].emptySync = flagStep(stateReg.dir[d].emptySync,
                                            occ[d] != '0,
                                            portEdge[1-d]);
      stateNext.dir[d].aeSync = flagStep(stateReg.dir[d].aeSync,
                                         occ[d] > (PW+1)'(stateReg.offset),
                                         portEdge[1-d]);
      // Full-side flags step on the writing port's edges
      stateNext.dir[d].fullSync = flagStep(stateReg.dir[d].fullSync,
                                           occ[d] != DEPTH_C,
                                           portEdge[d]);
      stateNext.dir[d].afSync = flagStep(stateReg.dir[d].afSync,
                                         occ[d] < (PW+1)'(DEPTH_C - (PW+1)'(stateReg.offset)),
                                         portEdge[d]);
    end

    // Reset: pointers home, flags to reset levels; samplers keep running
    // Mailbox words are kept: only their flags say whether mail is new
    if (rst) begin
      for (int d = 0; d < 2; d++) begin
        stateNext.dir[d].wrPtrGray = '0;
        stateNext.dir[d].rdPtrGray = '0;
        stateNext.dir[d].bufCount  = 2'h0;
        stateNext.dir[d].outWord   = '0;
        stateNext.dir[d].mailFlagN = `MAIL_FLAG_RST;
        stateNext.dir[d].emptySync = `SYNC_CLEAR;
        stateNext.dir[d].aeSync    = `SYNC_CLEAR;
        stateNext.dir[d].fullSync  = `SYNC_CLEAR;
        stateNext.dir[d].afSync    = `SYNC_SET;
      end
      // Offset follows the straps until release, then holds for both queues
      stateNext.offset = offsetOf(stateReg.selStable);
    end
  end

  // Single register bank; reset is applied through the next-state logic
  // Limitation: the pin samplers are not reset, so rst must be held for
  // a few mclk edges to flush unknown values out of them
  always_ff @(posedge mclk) begin
    stateReg <= stateNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus driven only when selected and reading
  assign portADataOe = ~stateReg.port[0].stable.selectN
                       & ~stateReg.port[0].stable.writeNotRead;
  assign portBDataOe = ~stateReg.port[1].stable.selectN
                       & ~stateReg.port[1].stable.writeNotRead;
  assign portADataOut = stateReg.port[0].dataOut;
  assign portBDataOut = stateReg.port[1].dataOut;

  // Port A reads direction 1 and writes direction 0; port B the reverse
  // Every flag below is a flip-flop output, so no decode glitch reaches a pin
  assign portANotEmpty     = stateReg.dir[1].emptySync[1];
  assign portAAlmostEmptyN = stateReg.dir[1].aeSync[1];
  assign portANotFull      = stateReg.dir[0].fullSync[1];
  assign portAAlmostFullN  = stateReg.dir[0].afSync[1];
  assign portBNotEmpty     = stateReg.dir[0].emptySync[1];
  assign portBAlmostEmptyN = stateReg.dir[0].aeSync[1];
  assign portBNotFull      = stateReg.dir[1].fullSync[1];
  assign portBAlmostFullN  = stateReg.dir[1].afSync[1];
  assign aToBMailFlagN     = stateReg.dir[0].mailFlagN;
  assign bToAMailFlagN     = stateReg.dir[1].mailFlagN;

endmodule

// file: sim/bidir_queue_port_sva.sv
// Concurrent checks on the two-way queue port block
module bidir_queue_port_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic portAClock,
  input wire logic portASelectN,
  input wire logic portAWriteNotRead,
  input wire logic portATransferEnable,
  input wire logic portAMailboxSelect,
  input wire logic portADataOe,
  input wire logic portANotFull,
  input wire logic portAAlmostFullN,
  input wire logic portBSelectN,
  input wire logic portBWriteNotRead,
  input wire logic portBTransferEnable,
  input wire logic portBMailboxSelect,
  input wire logic portBDataOe,
  input wire logic portBNotEmpty,
  input wire logic portBAlmostEmptyN,
  input wire logic aToBMailFlagN
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       aSeen1;  // Port A clock, first sample
  logic       aSeen2;  // Second sample
  logic       aSeen3;  // Previous second sample
  logic [1:0] aEdges;  // Port A edges since reset, stops at 3

  // Count edges as the block finds them, so the count never runs ahead of it
  always_ff @(posedge mclk) begin
    aSeen1 <= portAClock;
    aSeen2 <= aSeen1;
    aSeen3 <= aSeen2;
    if (rst) begin
      aEdges <= 2'h0;
    end else if (aSeen2 && !aSeen3 && aEdges != 2'h3) begin
      aEdges <= aEdges + 2'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  chk_oe_drive_a:
    assert property ((!portASelectN && !portAWriteNotRead) [*3] |-> portADataOe)
    else $error("port A bus not driven while selected for read");
  chk_oe_float_b:
    assert property ((portBSelectN || portBWriteNotRead) [*3] |-> !portBDataOe)
    else $error("port B bus driven while not selected for read");
  chk_reset_levels:
    assert property ($fell(rst) |-> !portANotFull && !portBNotEmpty && !portBAlmostEmptyN
                     && portAAlmostFullN && aToBMailFlagN)
    else $error("flag levels wrong right after reset");
  chk_mail_set:
    assert property ($fell(aToBMailFlagN) |-> $past(!portASelectN && portAWriteNotRead
                     && portATransferEnable && portAMailboxSelect, 3))
    else $error("mail flag fell without a port A mailbox write");
  chk_mail_clear:
    assert property ($rose(aToBMailFlagN) |-> $past(!portBSelectN && !portBWriteNotRead
                     && portBTransferEnable && portBMailboxSelect, 3))
    else $error("mail flag rose without a port B mailbox read");
  chk_ae_table:
    assert property (portBAlmostEmptyN |-> portBNotEmpty)
    else $error("almost-empty high while queue flagged empty");
  chk_full_release:
    assert property (portANotFull |-> aEdges >= 2'h2)
    else $error("not-full rose before two port A edges");
  chk_full_af:
    assert property ($fell(portANotFull) |-> !portAAlmostFullN)
    else $error("full without almost-full");

  // Main scenarios reached
  cover property ($rose(portBNotEmpty));
  cover property ($fell(aToBMailFlagN));
  cover property ($fell(portANotFull));
endmodule

bind bidir_queue_port bidir_queue_port_sva i_bidir_queue_port_sva (.*);

// file: sim/port_host.sv
// Bus master model standing on one port of the queue block
`include "bidir_queue_params.svh"
module port_host #(
  parameter int PHASE = 52
) (
  input  wire logic               mclk,
  output logic                    portClock,
  output logic                    selectN,
  output logic                    writeNotRead,
  output logic                    transferEnable,
  output logic                    mailboxSelect,
  output logic [`WORD_W-1:0]      dataIn,
  input  wire logic [`WORD_W-1:0] dataOut,
  input  wire logic               dataOe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [`WORD_W-1:0] drive;  // Host's own bus value

  // Resolved bus level; the block wins while it drives
  assign dataIn = dataOe ? dataOut : drive;

  // Free-running 800 ns port clock, edges 2 ns after an mclk edge
  initial begin
    portClock = 1'b0;
    #(PHASE);
    forever #400 portClock = ~portClock;
  end

  // Idle levels at time zero
  initial begin
    selectN = 1'b1;
    writeNotRead = 1'b0;
    transferEnable = 1'b0;
    mailboxSelect = 1'b0;
    drive = '0;
  end

  ////////////////////////////////////////
  // One port cycle; selects only move while enable is low or held over the edge
  task automatic xfer(input logic en, input logic wr, input logic mb,
                      input logic [`WORD_W-1:0] wd, output logic [`WORD_W-1:0] rd);
    @(negedge portClock);
    @(posedge mclk);
    #2;
    selectN = 1'b0;
    writeNotRead = wr;
    mailboxSelect = mb;
    transferEnable = en;
    if (wr) begin
      drive = wd;
    end
    @(posedge portClock);
    @(negedge portClock);
    @(posedge mclk);
    #2;
    transferEnable = 1'b0;
    drive = ~drive;  // Released bus must not look held
    @(posedge portClock);
    #2;
    rd = dataOut;
  endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the two-way queue port block
`include "bidir_queue_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic               mclk = 1'b0;  // Block clock, 100 ns
  logic               rst = 1'b1;  // High from time zero
  logic               offsetSelectLo = 1'b0;
  logic               offsetSelectHi = 1'b0;
  logic               portAClock, portASelectN, portAWriteNotRead, portATransferEnable;
  logic               portAMailboxSelect, portADataOe, portANotEmpty, portAAlmostEmptyN;
  logic               portANotFull, portAAlmostFullN, aToBMailFlagN, bToAMailFlagN;
  logic               portBClock, portBSelectN, portBWriteNotRead, portBTransferEnable;
  logic               portBMailboxSelect, portBDataOe, portBNotEmpty, portBAlmostEmptyN;
  logic               portBNotFull, portBAlmostFullN;
  logic [`WORD_W-1:0] portADataIn, portADataOut, portBDataIn, portBDataOut;
  logic [`WORD_W-1:0] rd;  // Word seen by the last host cycle
  int                 nMismatch = 0;
  int                 cmpCount = 0;
  int                 x;  // Offset expected from the straps

  bidir_queue_port i_bidir_queue_port (.*);

  port_host #(.PHASE(52)) i_port_host_a (.mclk(mclk), .portClock(portAClock),
    .selectN(portASelectN), .writeNotRead(portAWriteNotRead),
    .transferEnable(portATransferEnable), .mailboxSelect(portAMailboxSelect),
    .dataIn(portADataIn), .dataOut(portADataOut), .dataOe(portADataOe));
  // Port B a different phase, so the two sides never share edges
  port_host #(.PHASE(352)) i_port_host_b (.mclk(mclk), .portClock(portBClock),
    .selectN(portBSelectN), .writeNotRead(portBWriteNotRead),
    .transferEnable(portBTransferEnable), .mailboxSelect(portBMailboxSelect),
    .dataIn(portBDataIn), .dataOut(portBDataOut), .dataOe(portBDataOe));

  always #50 mclk = ~mclk;

  ////////////////////////////////////////
  // Queue word pattern, distinct per index
  function automatic logic [`WORD_W-1:0] pat(input int i);
    return {28'ha5c3e1d, i[7:0]};
  endfunction

  task automatic check(input logic [`WORD_W-1:0] seen, input logic [`WORD_W-1:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrapUp();
    $display("TB: %0d compares, %0d mismatches", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Four port periods: two sync edges plus phase slack
  task automatic settle();
    repeat (32) @(posedge mclk);
    #2;
  endtask

  task automatic doReset(input logic [1:0] sel);
    @(posedge mclk);
    #2;
    rst = 1'b1;
    {offsetSelectHi, offsetSelectLo} = sel;
    repeat (20) @(posedge mclk);
    #2;
    rst = 1'b0;
    @(posedge mclk);
    #2;
    check(portANotFull, 1'b0);
    check(portAAlmostFullN, 1'b1);
    check(aToBMailFlagN, 1'b1);
    check(bToAMailFlagN, 1'b1);
    check(portAAlmostEmptyN, 1'b0);
    check(portBAlmostFullN, 1'b1);
    settle();
    check(portANotFull, 1'b1);
    check(portBNotFull, 1'b1);
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    for (int s = 0; s < 4; s++) begin
      doReset(s[1:0]);
      x = 4 * (s + 1);  // Offset for straps {hi,lo}
      for (int i = 0; i < x; i++) i_port_host_a.xfer(1'b1, 1'b1, 1'b0, pat(i), rd);
      settle();
      check(portBNotEmpty, 1'b1);
      check(portBAlmostEmptyN, 1'b0);
      i_port_host_a.xfer(1'b1, 1'b1, 1'b0, pat(x), rd);
      settle();
      check(portBAlmostEmptyN, 1'b1);
    end
    $display("TB: offset test done");
    // Fill to the top, watching the almost-full boundary
    for (int i = x + 1; i < 64; i++) begin
      i_port_host_a.xfer(1'b1, 1'b1, 1'b0, pat(i), rd);
      check(portAAlmostFullN, 1'((i + 1) < 64 - x));
    end
    check(portANotFull, 1'b0);
    i_port_host_a.xfer(1'b1, 1'b1, 1'b0, '1, rd);  // Write into a full queue
    $display("TB: fill test done");
    // Mailbox, with selects moved under a low enable first
    i_port_host_a.xfer(1'b0, 1'b1, 1'b1, 36'h0_dead_beef, rd);
    check(aToBMailFlagN, 1'b1);
    i_port_host_a.xfer(1'b1, 1'b1, 1'b1, 36'h1_2345_6789, rd);
    check(aToBMailFlagN, 1'b0);
    i_port_host_a.xfer(1'b1, 1'b1, 1'b1, 36'h2_bad0_bad0, rd);
    i_port_host_b.xfer(1'b1, 1'b0, 1'b1, '0, rd);
    check(rd, 36'h1_2345_6789);
    check(aToBMailFlagN, 1'b1);
    $display("TB: mailbox test done");
    // Drain in order; the refused word must never show
    for (int i = 0; i < 64; i++) begin
      i_port_host_b.xfer(1'b1, 1'b0, 1'b0, '0, rd);
      check(rd, pat(i));
    end
    settle();
    check(portBNotEmpty, 1'b0);
    i_port_host_b.xfer(1'b1, 1'b0, 1'b0, '0, rd);
    check(rd, pat(63));
    check(portANotFull, 1'b1);
    check(portAAlmostFullN, 1'b1);
    $display("TB: drain test done");
    // Reverse direction, flags on the port A clock
    i_port_host_b.xfer(1'b1, 1'b1, 1'b0, 36'h3_0f0f_0f0f, rd);
    settle();
    check(portANotEmpty, 1'b1);
    check(portAAlmostEmptyN, 1'b0);
    i_port_host_a.xfer(1'b1, 1'b0, 1'b0, '0, rd);
    check(rd, 36'h3_0f0f_0f0f);
    // Reverse mailbox: port B writes, port A reads
    i_port_host_b.xfer(1'b1, 1'b1, 1'b1, 36'h4_5a5a_5a5a, rd);
    check(bToAMailFlagN, 1'b0);
    i_port_host_a.xfer(1'b1, 1'b0, 1'b1, '0, rd);
    check(rd, 36'h4_5a5a_5a5a);
    check(bToAMailFlagN, 1'b1);
    $display("TB: reverse test done");
    wrapUp();
  end

  // Watchdog, about three times the expected run
  initial begin
    #1_000_000;
    nMismatch++;
    wrapUp();
  end
endmodule
